/* File: dsb_pkg.sv */
package dsb_pkg;

    // ****************************************************************
    // Instruction fields
    // ****************************************************************
    localparam int OP_MSB = 31;
    localparam int OP_LSB = 26;
    localparam int GRP_MSB = 31;
    localparam int GRP_LSB = 28;
    localparam int RS_MSB = 25;
    localparam int RS_LSB = 21;
    localparam int RT_MSB = 20;
    localparam int RT_LSB = 16;
    localparam int RTC_MSB = 19;
    localparam int RTC_LSB = 18;
    localparam int CC_MSB = 20;
    localparam int CC_LSB = 18;
    localparam int ND_BIT = 17;
    localparam int TF_BIT = 16;
    localparam int CO_BIT = 25;
    localparam int SA_MSB = 10;
    localparam int SA_LSB = 6;
    localparam int FN_MSB = 5;
    localparam int FN_LSB = 0;
    localparam int OFF_W = 16;
    localparam int OFF_SHIFT = 2;
    localparam int CC_W = 3;

    // ****************************************************************
    // Opcodes and function codes
    // ****************************************************************
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_REGISTER_IMMEDIATE_OPCODE_CLASS = 6'h01;
    localparam logic [5:0] OP_J = 6'h02;
    localparam logic [5:0] OP_JAL = 6'h03;
    localparam logic [5:0] OP_BEQ = 6'h04;
    localparam logic [5:0] OP_BRANCH_IF_EQUAL_LIKELY = 6'h14;
    localparam logic [5:0] OP_COP0 = 6'h10;
    localparam logic [5:0] OP_COP1 = 6'h11;
    localparam logic [5:0] OP_COPROCESSOR_TWO = 6'h12;
    localparam logic [3:0] GRP_BR = 4'h1;
    localparam logic [3:0] GRP_BRL = 4'h5;
    localparam logic [4:0] RT_NONNEG = 5'h01;
    localparam logic [4:0] RT_NONNEG_LINK = 5'h11;
    localparam logic [1:0] RTC_BRANCH = 2'h0;
    localparam logic [4:0] RS_BC = 5'h08;
    localparam logic [4:0] REG_ZERO = 5'h00;
    localparam logic [4:0] REG_LINK = 5'h1F;
    localparam logic [5:0] FN_JR = 6'h08;
    localparam logic [5:0] FN_JALR = 6'h09;
    localparam logic [5:0] FN_SLL = 6'h00;
    localparam logic [4:0] SA_PAUSE = 5'h05;
    localparam logic [5:0] FN_ERET = 6'h18;
    localparam logic [5:0] FN_DERET = 6'h1F;
    localparam logic [5:0] FN_WAIT = 6'h20;

    // ****************************************************************
    // Address steps in bytes
    // ****************************************************************
    localparam logic [7:0] SLOT_STEP = 8'h04;
    localparam logic [7:0] LINK_STEP = 8'h08;

endpackage : dsb_pkg

/* File: dsb_operand_fwd.sv */
module dsb_operand_fwd
    import dsb_pkg::*;
#(
    parameter int XLEN = 32
) (
    input wire logic [4:0] idx_i,
    input wire logic [XLEN-1:0] rf_data_i,
    input wire logic fwd_valid_i,
    input wire logic [4:0] fwd_idx_i,
    input wire logic [XLEN-1:0] fwd_data_i,
    output logic [XLEN-1:0] data_o
);

    // ****************************************************************
    // Bypass select
    // ****************************************************************
    // bypass older result
    // Register zero never forwards, so a stray write to it is harmless
    always_comb begin
        if (idx_i == REG_ZERO) begin
            data_o = '0;
        end else if (fwd_valid_i && (fwd_idx_i == idx_i)) begin
            data_o = fwd_data_i;
        end else begin
            data_o = rf_data_i;
        end
    end

endmodule : dsb_operand_fwd

/* File: dsb_target_adder.sv */
module dsb_target_adder
    import dsb_pkg::*;
#(
    parameter int XLEN = 32
) (
    input wire logic [XLEN-1:0] pc_i,
    input wire logic [OFF_W-1:0] offset_i,
    output logic [XLEN-1:0] target_o
);

    logic [XLEN-1:0] slot_pc;
    logic [XLEN-1:0] disp;

    // ****************************************************************
    // Target arithmetic
    // ****************************************************************
    // slot relative offset
    assign slot_pc = pc_i + XLEN'(SLOT_STEP);
    assign disp = XLEN'({{(XLEN - OFF_W - OFF_SHIFT){offset_i[OFF_W-1]}}, offset_i,
                         OFF_SHIFT'(0)});
    // wrapping add
    // Carry out is dropped on purpose: no overflow trap on branches
    assign target_o = slot_pc + disp;

endmodule : dsb_target_adder

/* File: dsb_branch_unit.sv */
module dsb_branch_unit
    import dsb_pkg::*;
#(
    parameter int XLEN = 32,
    parameter int CC_COUNT = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic release6_i,
    input wire logic flush_i,
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic [XLEN-1:0] pc_i,
    input wire logic [XLEN-1:0] rs_rf_data_i,
    input wire logic [XLEN-1:0] rt_rf_data_i,
    input wire logic fwd_valid_i,
    input wire logic [4:0] fwd_idx_i,
    input wire logic [XLEN-1:0] fwd_data_i,
    input wire logic [CC_COUNT-1:0] coprocessor_two_cond_i,
    input wire logic coprocessor_two_usable_i,
    output logic branch_pending_o,
    output logic redirect_o,
    output logic [XLEN-1:0] redirect_pc_o,
    output logic nullify_slot_o,
    output logic link_we_o,
    output logic [4:0] link_idx_o,
    output logic [XLEN-1:0] link_data_o,
    output logic exc_reserved_o,
    output logic exc_cop_unusable_o,
    output logic predict_taken_o,
    output logic bpred_use_o
);

    typedef struct packed {
        logic pend;
        logic taken;
        logic likely;
        logic [XLEN-1:0] target;
        logic redirect;
        logic [XLEN-1:0] redirect_pc;
        logic nullify;
        logic link_we;
        logic [XLEN-1:0] link_data;
        logic exc_ri;
        logic exc_cpu;
        logic pred_taken;
        logic bpred_use;
    } dsb_state_s;

    dsb_state_s st_reg;
    dsb_state_s st_next;

    // ****************************************************************
    // Field extraction
    // ****************************************************************
    logic [5:0] opcode;
    logic [4:0] rs_idx;
    logic [4:0] rt_idx;
    logic [CC_W-1:0] cc_sel;
    logic polarity_select;
    logic nullify_slot_flag;
    logic [XLEN-1:0] rs_val;
    logic [XLEN-1:0] rt_val;
    logic [XLEN-1:0] target;

    assign opcode = instr_i[OP_MSB:OP_LSB];
    assign rs_idx = instr_i[RS_MSB:RS_LSB];
    assign rt_idx = instr_i[RT_MSB:RT_LSB];
    assign cc_sel = instr_i[CC_MSB:CC_LSB];
    assign nullify_slot_flag = instr_i[ND_BIT];
    assign polarity_select = instr_i[TF_BIT];

    // ****************************************************************
    // Operands and target
    // ****************************************************************
    dsb_operand_fwd #(.XLEN(XLEN)) u_fwd_rs (
        .idx_i(rs_idx),
        .rf_data_i(rs_rf_data_i),
        .fwd_valid_i(fwd_valid_i),
        .fwd_idx_i(fwd_idx_i),
        .fwd_data_i(fwd_data_i),
        .data_o(rs_val)
    );

    dsb_operand_fwd #(.XLEN(XLEN)) u_fwd_rt (
        .idx_i(rt_idx),
        .rf_data_i(rt_rf_data_i),
        .fwd_valid_i(fwd_valid_i),
        .fwd_idx_i(fwd_idx_i),
        .fwd_data_i(fwd_data_i),
        .data_o(rt_val)
    );

    dsb_target_adder #(.XLEN(XLEN)) u_target (
        .pc_i(pc_i),
        .offset_i(instr_i[OFF_W-1:0]),
        .target_o(target)
    );

    // ****************************************************************
    // Decode of the handled branches
    // ****************************************************************
    logic is_coprocessor_two_br;
    logic is_eq;
    logic is_eq_likely;
    logic is_nonneg;
    logic is_nonneg_link;
    logic is_branch;

    assign is_coprocessor_two_br = (opcode == OP_COPROCESSOR_TWO) && (rs_idx == RS_BC);
    assign is_eq = (opcode == OP_BEQ);
    assign is_eq_likely = (opcode == OP_BRANCH_IF_EQUAL_LIKELY);
    assign is_nonneg = (opcode == OP_REGISTER_IMMEDIATE_OPCODE_CLASS) && (rt_idx == RT_NONNEG);
    assign is_nonneg_link = (opcode == OP_REGISTER_IMMEDIATE_OPCODE_CLASS) && (rt_idx == RT_NONNEG_LINK);
    assign is_branch = is_coprocessor_two_br || is_eq || is_eq_likely || is_nonneg || is_nonneg_link;

    // ****************************************************************
    // Control transfer classification, used on the delay slot
    // ****************************************************************
    logic is_cti;
    logic cti_special;
    logic cti_cop0;

    assign cti_special = (opcode == OP_SPECIAL) &&
                         ((instr_i[FN_MSB:FN_LSB] == FN_JR) ||
                          (instr_i[FN_MSB:FN_LSB] == FN_JALR) ||
                          ((instr_i[FN_MSB:FN_LSB] == FN_SLL) &&
                           (instr_i[SA_MSB:SA_LSB] == SA_PAUSE) &&
                           (rt_idx == REG_ZERO)));
    assign cti_cop0 = (opcode == OP_COP0) && instr_i[CO_BIT] &&
                      ((instr_i[FN_MSB:FN_LSB] == FN_ERET) ||
                       (instr_i[FN_MSB:FN_LSB] == FN_DERET) ||
                       (instr_i[FN_MSB:FN_LSB] == FN_WAIT));
    // Link-without-branch sits in the branch class of the register-immediate group
    assign is_cti = cti_special || cti_cop0 ||
                    (opcode == OP_J) || (opcode == OP_JAL) ||
                    (instr_i[GRP_MSB:GRP_LSB] == GRP_BR) ||
                    (instr_i[GRP_MSB:GRP_LSB] == GRP_BRL) ||
                    ((opcode == OP_REGISTER_IMMEDIATE_OPCODE_CLASS) && (instr_i[RTC_MSB:RTC_LSB] == RTC_BRANCH)) ||
                    (((opcode == OP_COP1) || (opcode == OP_COPROCESSOR_TWO)) && (rs_idx == RS_BC));

    // ****************************************************************
    // Condition evaluation at the branch step
    // ****************************************************************
    logic cond;
    logic likely;
    logic link;
    logic dec_ri;
    logic dec_cpu;
    logic cc_bit;

    // Out of range selects read as false rather than X
    assign cc_bit = (int'(cc_sel) < CC_COUNT) ? coprocessor_two_cond_i[cc_sel] : 1'b0;

    always_comb begin
        cond = 1'b0;
        likely = 1'b0;
        link = 1'b0;
        dec_ri = 1'b0;
        dec_cpu = 1'b0;
        if (is_coprocessor_two_br) begin
            cond = (cc_bit == polarity_select);
            likely = nullify_slot_flag;
            // removed coprocessor_two forms
            // A removed encoding faults first, before the unit is even looked at
            dec_ri = release6_i;
            dec_cpu = !release6_i && !coprocessor_two_usable_i;
        end else if (is_eq || is_eq_likely) begin
            cond = (rs_val == rt_val);
            likely = is_eq_likely;
            dec_ri = is_eq_likely && release6_i;
        end else if (is_nonneg || is_nonneg_link) begin
            cond = !rs_val[XLEN-1];
            link = is_nonneg_link;
            // keep zero form
            // With source zero the test is always true, giving the plain call form
            dec_ri = is_nonneg_link && release6_i && (rs_idx != REG_ZERO);
        end
    end

    // ****************************************************************
    // Sequencing
    // ****************************************************************
    logic br_fire;
    logic slot_fire;
    logic slot_fault;

    // A branch in the slot never opens a second window
    assign br_fire = instr_valid_i && !flush_i && !st_reg.pend && is_branch;
    assign slot_fire = instr_valid_i && !flush_i && st_reg.pend;
    assign slot_fault = slot_fire && release6_i && is_cti;

    always_comb begin
        st_next = st_reg;
        st_next.redirect = 1'b0;
        st_next.nullify = 1'b0;
        st_next.link_we = 1'b0;
        st_next.exc_ri = 1'b0;
        st_next.exc_cpu = 1'b0;
        st_next.pred_taken = 1'b0;
        st_next.bpred_use = 1'b0;
        if (flush_i) begin
            st_next.pend = 1'b0;
        end else if (br_fire) begin
            st_next.exc_ri = dec_ri;
            st_next.exc_cpu = dec_cpu;
            if (!dec_ri && !dec_cpu) begin
                st_next.pend = 1'b1;
                st_next.taken = cond;
                st_next.likely = likely;
                st_next.target = target;
                st_next.pred_taken = likely;
                st_next.bpred_use = !likely;
                st_next.link_we = link;
                st_next.link_data = pc_i + XLEN'(LINK_STEP);
            end
        end else if (slot_fire) begin
            st_next.pend = 1'b0;
            if (slot_fault) begin
                st_next.exc_ri = 1'b1;
            end else begin
                st_next.redirect = st_reg.taken;
                st_next.redirect_pc = st_reg.target;
                st_next.nullify = st_reg.likely && !st_reg.taken;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign branch_pending_o = st_reg.pend;
    assign redirect_o = st_reg.redirect;
    assign redirect_pc_o = st_reg.redirect_pc;
    assign nullify_slot_o = st_reg.nullify;
    assign link_we_o = st_reg.link_we;
    assign link_idx_o = REG_LINK;
    assign link_data_o = st_reg.link_data;
    assign exc_reserved_o = st_reg.exc_ri;
    assign exc_cop_unusable_o = st_reg.exc_cpu;
    assign predict_taken_o = st_reg.pred_taken;
    assign bpred_use_o = st_reg.bpred_use;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_taken_redirect;
        @(posedge clk_i) disable iff (!rst_b_i)
        (slot_fire && !slot_fault && st_reg.taken) |=>
            (redirect_o && (redirect_pc_o == $past(st_reg.target)));
    endproperty
    a_taken_redirect: assert property (p_taken_redirect)
        else $error("taken branch did not redirect after its slot");

    property p_likely_nullify;
        @(posedge clk_i) disable iff (!rst_b_i)
        (slot_fire && !slot_fault && st_reg.likely && !st_reg.taken) |=>
            (nullify_slot_o && !redirect_o);
    endproperty
    a_likely_nullify: assert property (p_likely_nullify)
        else $error("untaken likely branch did not nullify its slot");

    property p_no_double;
        @(posedge clk_i) disable iff (!rst_b_i)
        redirect_o |-> !nullify_slot_o;
    endproperty
    a_no_double: assert property (p_no_double)
        else $error("slot nullified on a taken branch");

    property p_link_value;
        @(posedge clk_i) disable iff (!rst_b_i)
        (br_fire && is_nonneg_link && !dec_ri) |=>
            (link_we_o && (link_idx_o == REG_LINK) &&
             (link_data_o == $past(pc_i) + XLEN'(LINK_STEP)));
    endproperty
    a_link_value: assert property (p_link_value)
        else $error("link write missing or wrong return address");

    property p_slot_cti;
        @(posedge clk_i) disable iff (!rst_b_i)
        (slot_fire && release6_i && is_cti) |=> (exc_reserved_o && !redirect_o);
    endproperty
    a_slot_cti: assert property (p_slot_cti)
        else $error("transfer in delay slot did not fault");

    property p_cop_unusable;
        @(posedge clk_i) disable iff (!rst_b_i)
        (br_fire && is_coprocessor_two_br && !release6_i && !coprocessor_two_usable_i) |=>
            (exc_cop_unusable_o && !branch_pending_o);
    endproperty
    a_cop_unusable: assert property (p_cop_unusable)
        else $error("coprocessor_two branch with unit off did not fault");

    property p_removed_likely;
        @(posedge clk_i) disable iff (!rst_b_i)
        (br_fire && release6_i && (is_eq_likely || is_coprocessor_two_br)) |=> exc_reserved_o;
    endproperty
    a_removed_likely: assert property (p_removed_likely)
        else $error("removed branch form did not fault");

    property p_zero_equal;
        @(posedge clk_i) disable iff (!rst_b_i)
        (br_fire && is_eq && (rs_idx == REG_ZERO) && (rt_idx == REG_ZERO)) |=>
            (branch_pending_o && st_reg.taken);
    endproperty
    a_zero_equal: assert property (p_zero_equal)
        else $error("equal branch on register zero not taken");

    property p_static_predict;
        @(posedge clk_i) disable iff (!rst_b_i)
        predict_taken_o |-> (!bpred_use_o && $past(likely));
    endproperty
    a_static_predict: assert property (p_static_predict)
        else $error("likely branch touched prediction tables");

    property p_flush_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
        flush_i |=> (!branch_pending_o && !redirect_o);
    endproperty
    a_flush_clear: assert property (p_flush_clear)
        else $error("flush left a branch pending or redirected");

    property p_call_kept;
        @(posedge clk_i) disable iff (!rst_b_i)
        (br_fire && is_nonneg_link && release6_i && (rs_idx == REG_ZERO)) |=>
            (branch_pending_o && link_we_o && !exc_reserved_o);
    endproperty
    a_call_kept: assert property (p_call_kept)
        else $error("plain call form faulted in newer release");

endmodule : dsb_branch_unit

/* File: tb.sv */
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

module tb
    import dsb_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Stimulus signals and counters
    // ****************************************************************
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic release6_i = 1'b0;
    logic flush_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [31:0] instr_i = 32'h0;
    logic [31:0] pc_i = 32'h0;
    logic [31:0] rs_rf_data_i = 32'h0;
    logic [31:0] rt_rf_data_i = 32'h0;
    logic fwd_valid_i = 1'b0;
    logic [4:0] fwd_idx_i = 5'h05;
    logic [31:0] fwd_data_i = 32'h0000_0002;
    logic [7:0] coprocessor_two_cond_i = 8'hA5;
    logic coprocessor_two_usable_i = 1'b1;
    logic branch_pending_o, redirect_o, nullify_slot_o, link_we_o;
    logic exc_reserved_o, exc_cop_unusable_o, predict_taken_o, bpred_use_o;
    logic [31:0] redirect_pc_o, link_data_o;
    logic [4:0] link_idx_o;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] pc = 32'h0000_1000;
    logic [31:0] slot_cti [7] = '{32'h0080_0008, 32'h0800_0010, 32'h0C00_0010, 32'h0410_0004,
        32'h4200_0018, 32'h4200_0020, 32'h0000_0140};

    dsb_branch_unit u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .release6_i(release6_i),
        .flush_i(flush_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i),
        .rs_rf_data_i(rs_rf_data_i), .rt_rf_data_i(rt_rf_data_i), .fwd_valid_i(fwd_valid_i),
        .fwd_idx_i(fwd_idx_i), .fwd_data_i(fwd_data_i), .coprocessor_two_cond_i(coprocessor_two_cond_i),
        .coprocessor_two_usable_i(coprocessor_two_usable_i), .branch_pending_o(branch_pending_o),
        .redirect_o(redirect_o), .redirect_pc_o(redirect_pc_o), .nullify_slot_o(nullify_slot_o),
        .link_we_o(link_we_o), .link_idx_o(link_idx_o), .link_data_o(link_data_o),
        .exc_reserved_o(exc_reserved_o), .exc_cop_unusable_o(exc_cop_unusable_o),
        .predict_taken_o(predict_taken_o), .bpred_use_o(bpred_use_o));

    // Free running core clock, 10 ns period
    always #5 clk_i = ~clk_i;

    // Hang guard, far above the roughly 180 cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            test_done();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Expected target: slot address plus sign-extended word offset, wrapping
    function automatic logic [31:0] tgt(input logic [31:0] p, input logic [15:0] off);
        return p + 32'h4 + {{14{off[15]}}, off, 2'b00};
    endfunction : tgt

    // Coprocessor branch word from select, nullify and polarity bits
    function automatic logic [31:0] cw(input logic [2:0] cc, input logic nd, input logic tf);
        return {OP_COPROCESSOR_TWO, RS_BC, cc, nd, tf, 16'h0020};
    endfunction : cw

    // Side inputs change on an edge, one cycle ahead of the next branch
    task automatic setc(input logic r6, input logic use2, input logic fv);
        @(posedge clk_i);
        release6_i <= r6;
        coprocessor_two_usable_i <= use2;
        fwd_valid_i <= fv;
    endtask : setc

    // Branch then slot back to back; eb = pend,link,pred,bpred,exr,exu; es = redir,null,exr
    task automatic run(input logic [31:0] w, input logic [31:0] sw, input logic [31:0] rsd,
        input logic [31:0] rtd, input logic [5:0] eb, input logic [2:0] es);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= w;
        pc_i <= pc;
        rs_rf_data_i <= rsd;
        rt_rf_data_i <= rtd;
        @(posedge clk_i);
        instr_i <= sw;
        pc_i <= pc + 32'h4;
        #1;
        `CHK("branch flags", eb, {branch_pending_o, link_we_o, predict_taken_o, bpred_use_o,
            exc_reserved_o, exc_cop_unusable_o})
        if (eb[4]) begin
            `CHK("link data", pc + 32'h8, link_data_o)
            `CHK("link index", 5'h1F, link_idx_o)
        end
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        #1;
        `CHK("slot flags", es, {redirect_o, nullify_slot_o, exc_reserved_o})
        if (es[2]) `CHK("target", tgt(pc, w[15:0]), redirect_pc_o)
    endtask : run

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        `CHK("reset outputs", 4'h0, {branch_pending_o, redirect_o, link_we_o, exc_reserved_o})
        @(posedge clk_i);
        rst_b_i <= 1'b1;
        // Equal compare uses every bit; r0 always equal; negative offset
        run(32'h1022_0010, 32'h0, 32'h1234_5678, 32'h1234_5678, 6'h24, 3'h4);
        run(32'h1022_0010, 32'h0, 32'h1234_5678, 32'h9234_5678, 6'h24, 3'h0);
        run(32'h1000_FFF0, 32'h0, 32'h1, 32'h2, 6'h24, 3'h4);
        // Likely forms are predicted taken and nullify when untaken; then the nonnegative compare, plain and linking
        run(32'h5022_0008, 32'h0, 32'h5, 32'h5, 6'h28, 3'h4);
        run(32'h5022_0008, 32'h0, 32'h5, 32'h6, 6'h28, 3'h2);
        run(32'h0421_0004, 32'h0, 32'h7FFF_FFFF, 32'h0, 6'h24, 3'h4);
        run(32'h0421_0004, 32'h0, 32'h8000_0000, 32'h0, 6'h24, 3'h0);
        run(32'h0431_0004, 32'h0, 32'h8000_0000, 32'h0, 6'h34, 3'h0);
        $display("test register branches done");
        // Target add wraps past the top of the address space
        pc = 32'hFFFF_FFF0;
        run(32'h1000_0010, 32'h0, 32'h0, 32'h0, 6'h24, 3'h4);
        pc = 32'h0000_2000;
        // Operand bypass beats the stale register file value
        setc(1'b0, 1'b1, 1'b1);
        run(32'h10A6_0010, 32'h0, 32'h1, 32'h2, 6'h24, 3'h4);
        setc(1'b0, 1'b1, 1'b0);
        $display("test wrap and bypass done");
        // Every select, polarity and nullify combination against the flags
        for (int i = 0; i < 32; i++) begin
            automatic logic tk = (coprocessor_two_cond_i[i[4:2]] == i[0]);
            run(cw(i[4:2], i[1], i[0]), 32'h0, 32'h0, 32'h0, {2'b10, i[1], ~i[1], 2'b00},
                {tk, i[1] & ~tk, 1'b0});
        end
        setc(1'b0, 1'b0, 1'b0);
        run(cw(3'h0, 1'b0, 1'b1), 32'h0, 32'h0, 32'h0, 6'h01, 3'h0);
        $display("test coprocessor branches done");
        // Newer release drops forms and faults on transfers in the slot
        setc(1'b1, 1'b1, 1'b0);
        run(cw(3'h0, 1'b0, 1'b1), 32'h0, 32'h0, 32'h0, 6'h02, 3'h0);
        run(32'h5022_0008, 32'h0, 32'h5, 32'h5, 6'h02, 3'h0);
        run(32'h0471_0004, 32'h0, 32'h1, 32'h0, 6'h02, 3'h0);
        run(32'h0411_0004, 32'h0, 32'h8000_0000, 32'h0, 6'h34, 3'h4);
        for (int i = 0; i < 7; i++) begin
            run(32'h1000_0010, slot_cti[i], 32'h0, 32'h0, 6'h24, 3'h1);
        end
        setc(1'b0, 1'b1, 1'b0);
        $display("test newer release done");
        // Flush drops a pending branch without a redirect
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= 32'h1000_0010;
        @(posedge clk_i);
        flush_i <= 1'b1;
        instr_i <= 32'h0;
        @(posedge clk_i);
        flush_i <= 1'b0;
        instr_valid_i <= 1'b0;
        #1;
        `CHK("flush", 2'h0, {branch_pending_o, redirect_o})
        $display("test flush done");
        test_done();
    end

endmodule : tb
